// *** core/cmas_core_memory_address_select.sv ***
`timescale 1ns/1ns
module cmas_core_memory_address_select
  import cmas_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // axi4-lite write address
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // processor side
  input  wire cmas_timing_type    timing,
  input  wire cmas_interlace_type interlace,
  // stack side
  output logic [13:0]             addressLine,
  output logic                    addressRegClear,
  output logic                    dataRegClear,
  output logic                    memoryGo,
  output logic                    inhibitTiming,
  output logic                    readDirection,
  output logic                    writeDirection,
  output logic [3:0]              stackEnable,
  output logic [3:0]              inhibitEnable,
  output cmas_drive_type          xDrive,
  output cmas_drive_type          yDrive
);

  // =========================================================================
  // pulse decode
  logic atDataClr;
  logic atAddrLd;
  logic atAddrClr;
  logic atInhOn;
  logic atGoSet;

  // pulse-time events, one clock per pulse time
  assign atDataClr = timing.pulseStrobe && (timing.pulseTime == PT_DATA_CLR);
  assign atAddrLd  = timing.pulseStrobe && (timing.pulseTime == PT_ADDR_LD);
  assign atAddrClr = timing.pulseStrobe && (timing.pulseTime == PT_ADDR_CLR);
  assign atInhOn   = timing.pulseStrobe && (timing.pulseTime == PT_INH_ON);
  assign atGoSet   = timing.pulseStrobe && (timing.pulseTime == PT_GO_SET);

  // =========================================================================
  // software registers and internal state
  logic [13:0] nextAddr_r;
  logic        cycleEn_r;
  logic [13:0] addrReg_r;
  logic        memoryGo_r;
  logic        inhibit_r;
  logic        addrClr_r;
  logic        dataClr_r;

  // =========================================================================
  // address register and clear strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      addrReg_r <= 14'h0000;
    end else if (atAddrClr) begin
      addrReg_r <= 14'h0000;  // see RL9
    end else if (atAddrLd) begin
      addrReg_r <= addrReg_r | nextAddr_r;  // see RL10
    end
  end

  // strobes registered so they stand one clock
  always_ff @(posedge clk) begin
    if (rst) begin
      addrClr_r <= 1'b0;
      dataClr_r <= 1'b0;
    end else begin
      addrClr_r <= atAddrClr;  // see RL9
      dataClr_r <= atDataClr;  // see RL11
    end
  end

  assign addressRegClear = addrClr_r;
  assign dataRegClear    = dataClr_r;

  // =========================================================================
  // memory go and inhibit timing
  always_ff @(posedge clk) begin
    if (rst) begin
      memoryGo_r <= 1'b0;
    end else if (atGoSet) begin
      memoryGo_r <= cycleEn_r;  // see RL12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inhibit_r <= 1'b0;
    end else if (atInhOn) begin
      inhibit_r <= 1'b1;  // see RL13
    end else if (atDataClr) begin
      inhibit_r <= 1'b0;  // see RL13
    end
  end

  assign memoryGo      = memoryGo_r;
  assign inhibitTiming = inhibit_r;

  // =========================================================================
  // address source select
  always_comb begin
    if (!timing.bufferSelect) begin
      addressLine = addrReg_r;  // see RL1
    end else if (timing.portSelect) begin
      addressLine = interlace.wAddr;  // see RL1
    end else begin
      addressLine = interlace.yAddr;  // see RL1
    end
  end

  // =========================================================================
  // current direction terms
  assign readDirection  = memoryGo_r && !timing.phaseBitTwo;  // see RL7 RL12
  assign writeDirection = memoryGo_r && timing.phaseBitTwo
                          && (inhibit_r || timing.phaseBitOne);  // see RL7 RL12

  // =========================================================================
  // stack and octal digit decoders
  logic [7:0] yHiSel;
  logic [7:0] yLoSel;
  logic [7:0] xHiSel;
  logic [7:0] xLoSel;
  logic [1:0] stackNum;

  assign stackNum = addressLine[STACK_HI:STACK_LO];  // see RL2

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_octal
      // one-of-eight per octal digit
      assign yHiSel[gi] = (addressLine[Y_HI_POS +: 3] == 3'(gi));  // see RL3 RL4
      assign yLoSel[gi] = (addressLine[Y_LO_POS +: 3] == 3'(gi));  // see RL3 RL4
      assign xHiSel[gi] = (addressLine[X_HI_POS +: 3] == 3'(gi));  // see RL3 RL4
      assign xLoSel[gi] = (addressLine[X_LO_POS +: 3] == 3'(gi));  // see RL3 RL4
    end
    for (gi = 0; gi < STACKS; gi++) begin : g_stack
      assign stackEnable[gi]   = (stackNum == 2'(gi));  // see RL2 RL14
      assign inhibitEnable[gi] = stackEnable[gi] && inhibit_r;  // see RL14
    end
  endgenerate

  // =========================================================================
  // drive lines: pairing, direction and even-line reversal
  logic anyStack;
  assign anyStack = |stackEnable;  // stack enable gates the selectors

  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      logic xSel;
      logic ySel;
      logic oddLine;
      assign xSel    = anyStack && xHiSel[gi / 8] && xLoSel[gi % 8];  // see RL5 RL14
      assign ySel    = anyStack && yHiSel[gi / 8] && yLoSel[gi % 8];  // see RL5 RL14
      assign oddLine = (gi % 2) == 1;
      // odd lines: read uses pair a; even lines swap pairs
      assign xDrive.fwd[gi] = xSel && (oddLine ? readDirection : writeDirection);  // see RL6 RL8
      assign xDrive.rev[gi] = xSel && (oddLine ? writeDirection : readDirection);  // see RL6 RL8
      assign yDrive.fwd[gi] = ySel && (oddLine ? readDirection : writeDirection);  // see RL6 RL8
      assign yDrive.rev[gi] = ySel && (oddLine ? writeDirection : readDirection);  // see RL6 RL8
    end
  endgenerate

  // =========================================================================
  // axi4-lite write channel
  logic       awHeld_r;
  logic       wHeld_r;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic       bValid_r;
  logic [1:0] bResp_r;
  logic       doWrite;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready  = !wHeld_r && !bValid_r;
  assign doWrite       = awHeld_r && wHeld_r && !bValid_r;

  // capture address and data in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // register writes, byte lanes honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      nextAddr_r <= NEXT_ADDR_RST;
      cycleEn_r  <= CTRL_RST;
    end else if (doWrite) begin
      if (awAddr_r == OFS_NEXT_ADDR) begin
        if (wStrb_r[0]) nextAddr_r[7:0] <= wData_r[7:0];
        if (wStrb_r[1]) nextAddr_r[13:8] <= wData_r[13:8];
      end else if (awAddr_r == OFS_CTRL) begin
        if (wStrb_r[0]) cycleEn_r <= wData_r[CTRL_CYCLE_EN];
      end
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (rst) begin
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      if ((awAddr_r == OFS_NEXT_ADDR) || (awAddr_r == OFS_CTRL)) begin
        bResp_r <= RESP_OKAY;
      end else begin
        bResp_r <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp  = bResp_r;

  // =========================================================================
  // axi4-lite read channel
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic [31:0] statusWord;
  logic [31:0] decodeWord;

  assign s_axi_arready = !rValid_r;

  // live state of the block
  always_comb begin
    statusWord                 = 32'h0000_0000;
    statusWord[13:0]           = addrReg_r;
    statusWord[ST_GO_POS]      = memoryGo_r;
    statusWord[ST_INH_POS]     = inhibit_r;
    statusWord[ST_RD_POS]      = readDirection;
    statusWord[ST_WR_POS]      = writeDirection;
    statusWord[ST_STACK_POS +: 2] = stackNum;
  end

  assign decodeWord = {yHiSel, yLoSel, xHiSel, xLoSel};

  always_ff @(posedge clk) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r  <= RESP_OKAY;
      if (s_axi_araddr == OFS_NEXT_ADDR) begin
        rData_r <= {18'h00000, nextAddr_r};
      end else if (s_axi_araddr == OFS_CTRL) begin
        rData_r <= {31'h0000_0000, cycleEn_r};
      end else if (s_axi_araddr == OFS_STATUS) begin
        rData_r <= statusWord;
      end else if (s_axi_araddr == OFS_DECODE) begin
        rData_r <= decodeWord;
      end else begin
        rData_r <= 32'h0000_0000;
        rResp_r <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata  = rData_r;
  assign s_axi_rresp  = rResp_r;

endmodule

// *** core/cmas_pkg.sv ***
// Behaviour
// RL1: address lines take the address register, or W/Y interlace address during buffer timing.
// RL2: two top address lines pick one of four 4096-word stacks.
// RL3: X and Y each split into two octal digits, each one-of-eight decoded.
// RL4: Y is address bits 11..6, X bits 5..0; upper digit is barred group.
// RL5: upper and lower digit selections pair to one of 64 X and 64 Y lines.
// RL6: each selected line drives both ways through two switches and two sinks.
// RL7: read = go, not phase two; write = go, phase two, inhibit or phase one.
// RL8: even-numbered drive lines get reversed current polarity against odd ones.
// RL9: address register is cleared by its clear strobe at pulse time T10.
// RL10: new address loads at T9; stack and coordinate decode follow at once.
// RL11: data register clear strobe fires at pulse time T8.
// RL12: memory go sets when a new cycle starts and qualifies direction terms.
// RL13: inhibit timing turns on at T21 and stays on until T8.
// RL14: stack bits give four stack enables gating selectors and, with inhibit timing, inhibit drivers.
package cmas_pkg;

  // =========================================================================
  // geometry
  localparam int ADDR_W      = 14;
  localparam int LINES       = 64;
  localparam int STACKS      = 4;
  localparam int STACK_HI    = 13;
  localparam int STACK_LO    = 12;
  localparam int Y_HI_POS    = 9;   // barred Y octal digit, bits 11..9
  localparam int Y_LO_POS    = 6;
  localparam int X_HI_POS    = 3;   // barred X octal digit, bits 5..3
  localparam int X_LO_POS    = 0;

  // =========================================================================
  // pulse times of the computer cycle
  localparam logic [4:0] PT_DATA_CLR = 5'h08;  // T8
  localparam logic [4:0] PT_ADDR_LD  = 5'h09;  // T9
  localparam logic [4:0] PT_ADDR_CLR = 5'h0A;  // T10
  localparam logic [4:0] PT_INH_ON   = 5'h15;  // T21
  localparam logic [4:0] PT_GO_SET   = 5'h08;  // T8, new memory cycle

  // =========================================================================
  // register map (byte addresses)
  localparam logic [3:0] OFS_NEXT_ADDR = 4'h0;
  localparam logic [3:0] OFS_CTRL      = 4'h4;
  localparam logic [3:0] OFS_STATUS    = 4'h8;
  localparam logic [3:0] OFS_DECODE    = 4'hC;
  localparam logic [13:0] NEXT_ADDR_RST = 14'h0000;
  localparam int CTRL_CYCLE_EN   = 0;
  localparam logic CTRL_RST      = 1'b0;
  localparam int ST_GO_POS       = 16;
  localparam int ST_INH_POS      = 17;
  localparam int ST_RD_POS       = 18;
  localparam int ST_WR_POS       = 19;
  localparam int ST_STACK_POS    = 20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // =========================================================================
  // carriers
  typedef struct packed {
    logic [13:0] wAddr;  // W-channel interlace address
    logic [13:0] yAddr;  // Y-channel interlace address
  } cmas_interlace_type;

  typedef struct packed {
    logic [4:0] pulseTime;  // T number of the current pulse
    logic       pulseStrobe;  // first clock of that pulse time
    logic       phaseBitOne;
    logic       phaseBitTwo;
    logic       bufferSelect;  // buffer-select timing term
    logic       portSelect;  // W port when high, Y port when low
  } cmas_timing_type;

  typedef struct packed {
    logic [63:0] fwd;  // switch A / sink B pair conducts
    logic [63:0] rev;  // switch B / sink A pair conducts
  } cmas_drive_type;

endpackage

// *** dv/cmas_checker.sv ***
`timescale 1ns/1ns
module cmas_checker
  import cmas_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // processor side
  input wire cmas_timing_type    timing,
  input wire cmas_interlace_type interlace,
  // stack side
  input wire logic [13:0]        addressLine,
  input wire logic               addressRegClear,
  input wire logic               dataRegClear,
  input wire logic               memoryGo,
  input wire logic               inhibitTiming,
  input wire logic               readDirection,
  input wire logic               writeDirection,
  input wire logic [3:0]         stackEnable,
  input wire logic [3:0]         inhibitEnable,
  input wire cmas_drive_type     xDrive,
  input wire cmas_drive_type     yDrive
);
  // ==========================================
  // helper terms
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        at8;
  logic        at10;
  logic        at21;
  logic [63:0] xSel;
  logic [63:0] ySel;
  // pulse-time events and selected lines
  assign at8  = timing.pulseStrobe && timing.pulseTime == PT_DATA_CLR;
  assign at10 = timing.pulseStrobe && timing.pulseTime == PT_ADDR_CLR;
  assign at21 = timing.pulseStrobe && timing.pulseTime == PT_INH_ON;
  assign xSel = 64'h1 << addressLine[5:0];
  assign ySel = 64'h1 << addressLine[11:6];
  // a strobe high for exactly one cycle
  sequence oneShot(s);
    s ##1 !s;
  endsequence
  buffer_mux_a: assert property (timing.bufferSelect |->
    addressLine == (timing.portSelect ? interlace.wAddr : interlace.yAddr)) else $error("mux");
  stack_select_a: assert property (
    stackEnable == 4'h1 << addressLine[13:12]) else $error("stack");
  inhibit_gate_a: assert property (
    inhibitEnable == (stackEnable & {4{inhibitTiming}})) else $error("inhibit gate");
  read_dir_a: assert property (
    readDirection == (memoryGo && !timing.phaseBitTwo)) else $error("read dir");
  write_dir_a: assert property (
    writeDirection == (memoryGo && timing.phaseBitTwo && (inhibitTiming || timing.phaseBitOne)))
    else $error("write dir");
  addr_clear_a: assert property (at10 |=> oneShot(addressRegClear)) else $error("addr clr");
  data_clear_a: assert property (at8 |=> oneShot(dataRegClear)) else $error("data clr");
  inhibit_on_a: assert property (at21 |=> inhibitTiming) else $error("inh on");
  inhibit_off_a: assert property (at8 |=> !inhibitTiming) else $error("inh off");
  one_line_a: assert property (
    ((xDrive.fwd | xDrive.rev) & ~xSel) == 64'h0 && ((yDrive.fwd | yDrive.rev) & ~ySel) == 64'h0)
    else $error("extra line");
  x_polarity_a: assert property (
    {xDrive.fwd[addressLine[5:0]], xDrive.rev[addressLine[5:0]]} == (addressLine[0] ?
    {readDirection, writeDirection} : {writeDirection, readDirection})) else $error("polarity");
endmodule

bind cmas_core_memory_address_select cmas_checker chk_u (.clk, .rst, .timing, .interlace,
  .addressLine, .addressRegClear, .dataRegClear, .memoryGo, .inhibitTiming, .readDirection,
  .writeDirection, .stackEnable, .inhibitEnable, .xDrive, .yDrive);

// *** dv/cmas_core_memory_address_select_test.sv ***
`timescale 1ns/1ns
module cmas_core_memory_address_select_test
  import cmas_pkg::*;
;
  // ==========================================
  // bench signals
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         awAddr, arAddr;
  logic [3:0]         wStrb = 4'hF;
  logic [31:0]        wData, rData, got;
  logic [31:0]        seed = 32'hEFFE;
  logic [1:0]         bResp, rResp, resp, xDir, yDir, clrSeen;
  logic               awValid, awReady, wValid, wReady, bValid, bReady;
  logic               arValid, arReady, rValid, rReady, arClr, drClr, rE, wE;
  logic               memoryGo, inhibitTiming, rdDir, wrDir;
  logic [13:0]        addressLine, lineSeen, a;
  logic [3:0]         stackEnable, inhibitEnable;
  logic [5:0]         xLine, yLine;
  logic [6:0]         xCnt, yCnt;
  cmas_timing_type    timing;
  cmas_interlace_type interlace;
  cmas_drive_type     xDrive, yDrive;
  int                 mismatches = 0;
  int                 n_tests = 0;
  // clock
  always #2 clk = ~clk;
  // design and stack models
  cmas_core_memory_address_select dut_u (.clk(clk), .rst(rst), .timing(timing),
    .interlace(interlace), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .addressLine(addressLine), .addressRegClear(arClr), .dataRegClear(drClr),
    .memoryGo(memoryGo), .inhibitTiming(inhibitTiming), .readDirection(rdDir),
    .writeDirection(wrDir), .stackEnable(stackEnable), .inhibitEnable(inhibitEnable),
    .xDrive(xDrive), .yDrive(yDrive));
  cmas_stack_model xm_u (.drive(xDrive), .line(xLine), .dir(xDir), .nLines(xCnt));
  cmas_stack_model ym_u (.drive(yDrive), .line(yLine), .dir(yDir), .nLines(yCnt));
  // ==========================================
  // expectations and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] expDec(input logic [13:0] v);
    return {8'h01 << v[11:9], 8'h01 << v[8:6], 8'h01 << v[5:3], 8'h01 << v[2:0]};
  endfunction
  function automatic logic [1:0] expDir(input logic odd, input logic r, input logic w);
    return odd ? {r, w} : {w, r};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang();
    mismatches++;
    $display("BAD %0t no answer", $time);
    conclude();
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [3:0] ad, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awAddr  <= ad;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1 && n < 100);
    r = bResp;
    bReady <= 1'b0;
    if (bValid !== 1'b1) hang();
  endtask
  // axi4-lite read
  task automatic rd(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    arAddr  <= ad;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1 && n < 100);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (rValid !== 1'b1) hang();
  endtask
  // one pulse time with its strobe, outputs caught just after the event edge
  task automatic pulse(input logic [4:0] t);
    @(posedge clk);
    timing.pulseTime   <= t;
    timing.pulseStrobe <= 1'b1;
    @(posedge clk);
    timing.pulseStrobe <= 1'b0;  // strobe stands for exactly one edge
    #1;
    clrSeen  = {arClr, drClr};
    lineSeen = addressLine;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady, timing, interlace} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_DECODE, got, resp);
    chk(got, expDec(14'h0000));
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h061F : seed[13:0];
      wr(OFS_NEXT_ADDR, {18'h0, a}, resp);
      pulse(PT_ADDR_CLR);
      chk(clrSeen, 2'h2);
      pulse(PT_ADDR_LD);
      chk(lineSeen, a);
      chk(stackEnable, 4'h1 << a[13:12]);
      rd(OFS_DECODE, got, resp);
      chk(got, expDec(a));
      @(posedge clk);
      timing.bufferSelect <= 1'b1;
      timing.portSelect   <= seed[20];
      interlace           <= {seed[27:14], ~seed[13:0]};
      @(posedge clk);
      #1;
      chk(addressLine, seed[20] ? seed[27:14] : {~seed[13:0]});
      @(posedge clk);
      timing.bufferSelect <= 1'b0;
    end
    $display("test addressing done");
    wr(OFS_NEXT_ADDR, 32'h0000061F, resp);
    pulse(PT_ADDR_CLR);
    pulse(PT_ADDR_LD);
    wr(OFS_CTRL, 32'h00000001, resp);
    pulse(PT_DATA_CLR);
    chk(clrSeen, 2'h1);
    chk({memoryGo, inhibitTiming}, 2'h2);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) pulse(PT_INH_ON);
      @(posedge clk);
      timing.phaseBitOne <= k[0];
      timing.phaseBitTwo <= k[1];
      @(posedge clk);
      #1;
      rE = !k[1];
      wE = k[1] && (k[2] || k[0]);
      chk({rdDir, wrDir}, {rE, wE});
      chk({xDir, yDir}, {expDir(1'b1, rE, wE), expDir(1'b0, rE, wE)});
      chk({xLine, yLine, xCnt, yCnt}, (rE | wE) ? {6'h1F, 6'h18, 7'h01, 7'h01} : 26'h0);
      chk({inhibitTiming, inhibitEnable}, {k[2], 3'h0, k[2]});
    end
    wr(OFS_CTRL, 32'h00000000, resp);
    pulse(PT_DATA_CLR);
    chk({memoryGo, inhibitTiming, rdDir, wrDir}, 4'h0);
    $display("test direction done");
    wr(OFS_STATUS, 32'hFFFFFFFF, resp);
    chk(resp, RESP_SLVERR);
    rd(4'h6, got, resp);
    chk({got[29:0], resp}, {30'h0, RESP_SLVERR});
    rd(OFS_NEXT_ADDR, got, resp);
    chk(got, 32'h0000061F);
    rd(OFS_STATUS, got, resp);
    chk(got, 32'h0000061F);
    rd(OFS_CTRL, got, resp);
    chk({got, resp}, {32'h00000000, RESP_OKAY});
    $display("test bus errors done");
    conclude();
  end
endmodule

// *** dv/cmas_stack_model.sv ***
`timescale 1ns/1ns
module cmas_stack_model
  import cmas_pkg::*;
(
  // drive terms of one coordinate
  input  wire cmas_drive_type drive,
  // line seen conducting
  output logic [5:0]          line,
  output logic [1:0]          dir,
  output logic [6:0]          nLines
);
  // each line conducts through the switch-sink pair of either direction
  always_comb begin
    line   = 6'h00;
    dir    = 2'h0;
    nLines = 7'h00;
    for (int i = 0; i < LINES; i++) begin
      if (drive.fwd[i] || drive.rev[i]) begin
        line   = i[5:0];
        dir    = {drive.fwd[i], drive.rev[i]};
        nLines = nLines + 7'h01;
      end
    end
  end
endmodule
